//--- core/flash_host_pkg.sv
package flash_host_pkg;
    // =========================================
    // geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;

    // =========================================
    // command bytes
    localparam logic [7:0] CMD_SET_READ = 8'h00;
    localparam logic [7:0] CMD_SIGNATURE = 8'h90;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // =========================================
    // timing
    localparam int CLOCK_NS = 100;
    localparam int PROG_PULSE_NS = 10000;
    localparam int RECOVERY_NS = 6000;
    localparam int ERASE_PULSE_NS = 9500000;
    localparam int STROBE_CYCLES = 1;
    localparam int PROG_PULSE_CYC = (PROG_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int RECOVERY_CYC = (RECOVERY_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int ERASE_PULSE_CYC = (ERASE_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int MAX_PROG_TRIES = 25;
    localparam int MAX_ERASE_TRIES = 1000;
    localparam int CNT_W = 24;
    localparam int TRY_W = 10;

    // =========================================
    // user operations
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE = 3'h2,
        OP_SIGNATURE = 3'h3,
        OP_ABORT = 3'h4
    } op_e;

    typedef struct packed {
        op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_s;

    typedef struct packed {
        logic chip_sel_n;
        logic out_drv_n;
        logic wr_strobe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } pins_s;
endpackage

//--- core/flash_bus_cycle.sv
// one bus cycle on the flash pins: write or read, one clock phase per step
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic is_write,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] wdata,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output flash_host_pkg::pins_s pins,
    output logic [flash_host_pkg::DATA_W-1:0] rdata,
    output logic done
);
    import flash_host_pkg::*;

    // =========================================
    // phase sequencer
    typedef enum logic [3:0] {
        P_IDLE = 4'b0001,
        P_SETUP = 4'b0010,
        P_ACTIVE = 4'b0100,
        P_HOLD = 4'b1000
    } phase_e;

    phase_e phase_reg;
    phase_e phase_next;
    logic write_reg;
    pins_s pins_reg;
    logic [DATA_W-1:0] rdata_reg;

    wire active_phase = (phase_reg == P_ACTIVE);
    assign done = (phase_reg == P_HOLD);
    assign pins = pins_reg;
    assign rdata = rdata_reg;

    always_comb begin
        case (phase_reg)
            P_IDLE: phase_next = start ? P_SETUP : P_IDLE;
            P_SETUP: phase_next = P_ACTIVE;
            P_ACTIVE: phase_next = P_HOLD;
            P_HOLD: phase_next = P_IDLE;
            default: phase_next = P_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg <= P_IDLE;
            write_reg <= 1'b0;
            rdata_reg <= '0;
            pins_reg <= '{1'b1, 1'b1, 1'b1, '0, '0, 1'b0};
        end else begin
            phase_reg <= phase_next;
            if (phase_reg == P_IDLE && start) begin
                write_reg <= is_write;
                pins_reg.addr <= addr; // R3
                pins_reg.dq_out <= wdata;
                pins_reg.chip_sel_n <= 1'b0;
                pins_reg.dq_oe <= is_write;
            end
            // strobe low in setup->active; rising edge latches byte
            pins_reg.wr_strobe_n <= !(phase_next == P_ACTIVE && write_reg); // R6 R16
            pins_reg.out_drv_n <= !(phase_next == P_ACTIVE && !write_reg); // R1
            if (active_phase && !write_reg) begin
                rdata_reg <= dq_in; // R1
            end
            if (phase_reg == P_HOLD) begin
                pins_reg.chip_sel_n <= 1'b1;
                pins_reg.dq_oe <= 1'b0;
            end
        end
    end

    chk_read_no_drive: assert property (@(posedge clock) disable iff (sys_rst) // R1
        !pins_reg.out_drv_n |-> !pins_reg.dq_oe && pins_reg.wr_strobe_n)
        else $error("host drives data during read");
    chk_strobe_width: assert property (@(posedge clock) disable iff (sys_rst) // R6
        $fell(pins_reg.wr_strobe_n) |=> $rose(pins_reg.wr_strobe_n))
        else $error("write strobe width wrong");
endmodule // flash_bus_cycle

//--- core/flash_host.sv
// Function
// [R1] read: select and output-drive low, strobe high
// [R2] set-read command before array reads
// [R3] all 18 address lines carried to pins
// [R4] output-drive high floats device data bus
// [R5] commands need programming supply high
// [R6] command byte latched on strobe rise
// [R7] write cycles latch address and data
// [R8] device stop-timers end program and erase
// [R9] program pulse 10 us, recovery 6 us
// [R10] at most 25 program tries per byte
// [R11] all bytes zeroed before chip erase
// [R12] wait 6 us after program/erase write
// [R13] write may follow read immediately
// [R14] select high puts device in standby
// [R15] erase twice, erase-verify ends pulse
// [R16] program command then address and data
// [R17] two all-ones writes abort to read
// [R18] verify commands return location for compare
// [R19] signature: address 0 maker, 1 device
module flash_host
    import flash_host_pkg::*;
#(
    parameter int PROG_WAIT = flash_host_pkg::PROG_PULSE_CYC,
    parameter int RECOVER_WAIT = flash_host_pkg::RECOVERY_CYC,
    parameter int ERASE_WAIT = flash_host_pkg::ERASE_PULSE_CYC,
    parameter int LAST_ADDR = (1 << flash_host_pkg::ADDR_W) - 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    output logic req_ready,
    input flash_host_pkg::req_s req,
    output logic resp_valid,
    output logic [flash_host_pkg::DATA_W-1:0] resp_data,
    output logic resp_fail,
    input wire logic program_supply_high,
    output logic supply_enable,
    output logic chip_sel_n,
    output logic out_drv_n,
    output logic wr_strobe_n,
    output logic [flash_host_pkg::ADDR_W-1:0] addr_out,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output logic [flash_host_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe
);
    import flash_host_pkg::*;

    // =========================================
    // sequencer states
    typedef enum logic [11:0] {
        S_IDLE = 12'h001,
        S_SUPPLY = 12'h002,
        S_CMD1 = 12'h004,
        S_CMD2 = 12'h008,
        S_PULSE = 12'h010,
        S_VCMD = 12'h020,
        S_RECOVER = 12'h040,
        S_VREAD = 12'h080,
        S_CHECK = 12'h100,
        S_READ = 12'h200,
        S_DONE = 12'h400,
        S_ZERO = 12'h800
    } state_e;

    state_e state_reg;
    state_e state_next;
    req_s req_reg;
    logic [CNT_W-1:0] wait_reg;
    logic [TRY_W-1:0] tries_reg;
    logic [ADDR_W-1:0] walk_reg;
    logic erase_phase_reg;
    logic [DATA_W-1:0] resp_data_reg;
    logic resp_fail_reg;
    logic [CNT_W-1:0] stay_reg;
    logic cycle_start;
    logic cycle_write;
    logic [ADDR_W-1:0] cycle_addr;
    logic [DATA_W-1:0] cycle_data;
    logic [DATA_W-1:0] cycle_rdata;
    logic cycle_done;
    pins_s pins;

    flash_bus_cycle u_cycle (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(cycle_start),
        .is_write(cycle_write),
        .addr(cycle_addr),
        .wdata(cycle_data),
        .dq_in(dq_in),
        .pins(pins),
        .rdata(cycle_rdata),
        .done(cycle_done)
    );

    // =========================================
    // pin outputs
    assign chip_sel_n = pins.chip_sel_n; // R14
    assign out_drv_n = pins.out_drv_n; // R4
    assign wr_strobe_n = pins.wr_strobe_n;
    assign addr_out = pins.addr;
    assign dq_out = pins.dq_out;
    assign dq_oe = pins.dq_oe;
    assign resp_data = resp_data_reg;
    assign resp_fail = resp_fail_reg;

    // =========================================
    // decode
    wire is_prog = (req_reg.op == OP_PROGRAM);
    wire is_erase = (req_reg.op == OP_ERASE);
    wire is_sig = (req_reg.op == OP_SIGNATURE);
    wire is_abort = (req_reg.op == OP_ABORT);
    wire zeroing = is_erase && !erase_phase_reg;
    wire in_cycle = (state_reg == S_CMD1) || (state_reg == S_CMD2) ||
        (state_reg == S_VCMD) || (state_reg == S_VREAD) || (state_reg == S_READ) ||
        (state_reg == S_ZERO);
    wire wait_done = (wait_reg == '0);
    wire [DATA_W-1:0] expect_byte = zeroing ? ZERO_BYTE : (is_prog ? req_reg.data : ERASED_BYTE);
    wire verify_ok = (cycle_rdata == expect_byte);
    wire try_limit = is_prog || zeroing ? (tries_reg >= TRY_W'(MAX_PROG_TRIES)) // R10
        : (tries_reg >= TRY_W'(MAX_ERASE_TRIES));
    wire last_byte = (walk_reg == ADDR_W'(LAST_ADDR));
    wire [ADDR_W-1:0] op_addr = is_erase ? walk_reg : req_reg.addr;
    wire needs_supply = !(req_reg.op == OP_READ);

    assign req_ready = (state_reg == S_IDLE);
    assign supply_enable = (state_reg != S_IDLE) && needs_supply;
    assign cycle_start = in_cycle && !cycle_done;

    // command/address/data per state
    always_comb begin
        cycle_write = 1'b1;
        cycle_addr = op_addr;
        cycle_data = CMD_SET_READ;
        case (state_reg)
            S_CMD1: begin
                if (is_abort) cycle_data = CMD_RESET; // R17
                else if (is_sig) cycle_data = CMD_SIGNATURE;
                else if (is_erase && erase_phase_reg) cycle_data = CMD_ERASE; // R15
                else if (is_prog || zeroing) cycle_data = CMD_PROGRAM; // R16
                else cycle_data = CMD_SET_READ; // R2
            end
            S_CMD2: cycle_data = is_abort ? CMD_RESET : CMD_ERASE; // R15 R17
            S_ZERO: cycle_data = ZERO_BYTE; // R11
            S_PULSE: cycle_data = req_reg.data;
            S_VCMD: cycle_data = (is_erase && erase_phase_reg) ? CMD_ERASE_VERIFY // R15 R18
                : CMD_PROGRAM_VERIFY;
            S_VREAD, S_READ: cycle_write = 1'b0; // R18 R19
            default: cycle_data = CMD_SET_READ;
        endcase
        if (state_reg == S_CMD2 && !is_abort && !is_erase) cycle_data = req_reg.data; // R7
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: if (req_valid) state_next = S_SUPPLY;
            S_SUPPLY: begin
                if (req_reg.op == OP_READ && !program_supply_high) state_next = S_READ; // R2
                else if (program_supply_high) state_next = S_CMD1; // R5
            end
            S_CMD1: if (cycle_done) begin
                if (is_abort || (is_erase && erase_phase_reg)) state_next = S_CMD2;
                else if (is_prog) state_next = S_CMD2;
                else if (zeroing) state_next = S_ZERO;
                else state_next = S_READ; // R13
            end
            S_CMD2: if (cycle_done) state_next = is_abort ? S_DONE : S_PULSE;
            S_ZERO: if (cycle_done) state_next = S_PULSE;
            S_PULSE: if (wait_done) state_next = S_VCMD; // R8 R9
            S_VCMD: if (cycle_done) state_next = S_RECOVER;
            S_RECOVER: if (wait_done) state_next = S_VREAD; // R12
            S_VREAD: if (cycle_done) state_next = S_CHECK;
            S_CHECK: begin
                if (verify_ok && is_erase && !(erase_phase_reg && !last_byte) &&
                    !(!erase_phase_reg && !last_byte)) state_next = S_CMD1;
                else if (verify_ok && is_erase) state_next = S_VCMD;
                else if (verify_ok) state_next = S_DONE;
                else if (try_limit) state_next = S_DONE;
                else state_next = S_CMD1;
                if (verify_ok && is_erase && erase_phase_reg && last_byte) state_next = S_DONE;
                if (verify_ok && zeroing && !last_byte) state_next = S_CMD1;
            end
            S_READ: if (cycle_done) state_next = S_DONE;
            S_DONE: state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= S_IDLE;
            req_reg <= '{OP_READ, '0, '0};
            wait_reg <= '0;
            tries_reg <= '0;
            walk_reg <= '0;
            erase_phase_reg <= 1'b0;
            resp_data_reg <= '0;
            resp_fail_reg <= 1'b0;
            resp_valid <= 1'b0;
        end else begin
            state_reg <= state_next;
            resp_valid <= (state_next == S_DONE);
            if (state_reg == S_IDLE && req_valid) begin
                req_reg <= req;
                tries_reg <= '0;
                walk_reg <= '0;
                erase_phase_reg <= 1'b0;
                resp_fail_reg <= 1'b0;
            end
            if ((state_next == S_PULSE) && (state_reg != S_PULSE)) begin
                wait_reg <= CNT_W'(is_erase && erase_phase_reg ? ERASE_WAIT : PROG_WAIT); // R9
                tries_reg <= tries_reg + TRY_W'(1);
            end else if (state_next == S_RECOVER && state_reg != S_RECOVER) begin
                wait_reg <= CNT_W'(RECOVER_WAIT); // R12
            end else if (!wait_done) begin
                wait_reg <= wait_reg - CNT_W'(1);
            end
            if (state_reg == S_VREAD && cycle_done) resp_data_reg <= cycle_rdata;
            if (state_reg == S_READ && cycle_done) resp_data_reg <= cycle_rdata;
            if (state_reg == S_CHECK) begin
                if (!verify_ok && try_limit) resp_fail_reg <= 1'b1; // R10
                if (verify_ok && is_erase) begin
                    if (last_byte && !erase_phase_reg) begin
                        erase_phase_reg <= 1'b1; // R11
                        walk_reg <= '0;
                        tries_reg <= '0;
                    end else if (!last_byte) begin
                        walk_reg <= walk_reg + ADDR_W'(1);
                        if (!erase_phase_reg) tries_reg <= '0;
                    end
                end
            end
        end
    end

    // cycles spent in the current state, for the timing checks
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stay_reg <= '0;
        end else if (state_next != state_reg) begin
            stay_reg <= '0;
        end else begin
            stay_reg <= stay_reg + CNT_W'(1);
        end
    end

    // =========================================
    // checks
    chk_pulse_length: assert property (@(posedge clock) disable iff (sys_rst) // R9
        (state_reg == S_PULSE && state_next != S_PULSE) |->
        stay_reg >= CNT_W'(is_erase && erase_phase_reg ? ERASE_WAIT : PROG_WAIT))
        else $error("pulse cut short");
    chk_recover_wait: assert property (@(posedge clock) disable iff (sys_rst) // R12
        (state_reg == S_RECOVER && state_next != S_RECOVER) |->
        stay_reg >= CNT_W'(RECOVER_WAIT))
        else $error("read before recovery");
    chk_supply_gate: assert property (@(posedge clock) disable iff (sys_rst) // R5
        (state_reg == S_CMD1 && $past(state_reg) == S_SUPPLY) |-> $past(program_supply_high))
        else $error("command written without supply");
    chk_try_bound: assert property (@(posedge clock) disable iff (sys_rst) // R10
        (is_prog && state_reg == S_PULSE) |-> tries_reg <= TRY_W'(MAX_PROG_TRIES))
        else $error("too many program tries");
endmodule // flash_host

//--- verification/flash_dev_model.sv
module flash_dev_model #(
    parameter int PULSE_NS = 350,
    parameter int RECOVER_NS = 350,
    parameter int ERASE_NS = 750,
    parameter int LAST_ADDR = 3,
    parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hC3 // arbitrary value
) (
    input wire logic program_supply_high,
    input wire logic chip_sel_n,
    input wire logic out_drv_n,
    input wire logic wr_strobe_n,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr_out,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    output logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output int faults,
    output int verifies,
    output int aborts
);
    import flash_host_pkg::*;
    // ====================
    // array and command state
    logic [7:0] mem [logic [17:0]];
    logic [7:0] out_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [7:0] pdata;
    logic [17:0] wa, pa, va;
    logic sig = 0, verify = 0, setup_p = 0, setup_e = 0, prog_p = 0, erase_p = 0;
    logic prev_ff = 0, abort, was_p, was_e;
    time t_pulse = 0;
    time t_rec = 0;
    wire drive = !chip_sel_n && !out_drv_n && wr_strobe_n;
    assign dq_in = drive ? out_q : dq_oe ? dq_out : ~last_q;
    function automatic logic [7:0] rd(input logic [17:0] a);
        return mem.exists(a) ? mem[a] : ERASED_BYTE;
    endfunction
    // ====================
    // read cycles
    always @(negedge out_drv_n) begin
        if (!chip_sel_n) begin
            if ($time - t_rec < RECOVER_NS) faults++;
            if (!program_supply_high || !(sig || verify)) out_q = rd(addr_out);
            else if (verify) out_q = rd(va);
            else out_q = addr_out[0] ? DEVICE_CODE : MAKER_CODE;
        end
    end
    always @(posedge out_drv_n) last_q = out_q;
    // ====================
    // write cycles
    always @(negedge wr_strobe_n) if (!chip_sel_n) wa = addr_out;
    always @(posedge wr_strobe_n) begin
        last_q = dq_out;
        if (!chip_sel_n && program_supply_high) begin
            abort = dq_out == CMD_RESET && prev_ff;
            prev_ff = dq_out == CMD_RESET && !abort;
            if (abort) aborts++;
            if (!abort && prog_p && $time - t_pulse >= PULSE_NS) mem[pa] = rd(pa) & pdata;
            if (!abort && erase_p && $time - t_pulse >= ERASE_NS) mem.delete();
            {prog_p, erase_p, sig, verify} = '0;
            was_p = setup_p && !abort;
            was_e = setup_e && !abort;
            setup_p = 0;
            setup_e = 0;
            if (was_p) begin
                pa = wa;
                pdata = dq_out;
                prog_p = 1;
                t_pulse = $time;
                t_rec = $time;
            end else if (was_e && dq_out == CMD_ERASE) begin
                for (int a = 0; a <= LAST_ADDR; a++) if (rd(18'(a)) != ZERO_BYTE) faults++;
                erase_p = 1;
                t_pulse = $time;
                t_rec = $time;
            end else if (!abort) begin
                setup_p = dq_out == CMD_PROGRAM;
                setup_e = dq_out == CMD_ERASE;
                sig = dq_out == CMD_SIGNATURE;
                verify = dq_out == CMD_ERASE_VERIFY || dq_out == CMD_PROGRAM_VERIFY;
                va = dq_out == CMD_PROGRAM_VERIFY ? pa : wa;
                if (verify) t_rec = $time;
                if (dq_out == CMD_PROGRAM_VERIFY) verifies++;
            end
        end
    end
endmodule // flash_dev_model

//--- verification/test_flash_host.sv
module test_flash_host;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_host_pkg::*;
    // ====================
    // wiring
    localparam int LAST = 3;
    localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
    localparam logic [7:0] DEVICE = 8'hC3; // arbitrary value
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic program_supply_high = 1'b0;
    logic allow = 1'b1;
    logic pin_high = 1'b0;
    req_s req = '0;
    logic req_ready, resp_valid, resp_fail, supply_enable, chip_sel_n, out_drv_n, wr_strobe_n;
    logic dq_oe, fail;
    logic [ADDR_W-1:0] addr_out, a;
    logic [DATA_W-1:0] resp_data, dq_in, dq_out, got, d;
    logic [15:0] rnd = 16'h004B;
    logic [7:0] ref_mem [logic [17:0]];
    logic [17:0] q [$];
    int errors = 0;
    int compares = 0;
    int faults, verifies, aborts, strobes, base;
    always #50 clock = ~clock;
    always @(posedge clock) program_supply_high <= (supply_enable | pin_high) & allow;
    always @(negedge wr_strobe_n) strobes++;
    flash_host #(.PROG_WAIT(4), .RECOVER_WAIT(4), .ERASE_WAIT(8), .LAST_ADDR(LAST)) i_flash_host (
        .clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .resp_valid(resp_valid), .resp_data(resp_data), .resp_fail(resp_fail),
        .program_supply_high(program_supply_high), .supply_enable(supply_enable),
        .chip_sel_n(chip_sel_n), .out_drv_n(out_drv_n), .wr_strobe_n(wr_strobe_n),
        .addr_out(addr_out), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
    flash_dev_model #(.LAST_ADDR(LAST), .MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
        i_flash_dev_model (
        .program_supply_high(program_supply_high), .chip_sel_n(chip_sel_n),
        .out_drv_n(out_drv_n), .wr_strobe_n(wr_strobe_n), .addr_out(addr_out),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .faults(faults),
        .verifies(verifies), .aborts(aborts));
    // ====================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] ref_rd(input logic [17:0] x);
        return ref_mem.exists(x) ? ref_mem[x] : ERASED_BYTE;
    endfunction
    task automatic results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g, input string m);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t %s exp %h got %h", $time, m, e, g);
        end
    endtask
    task automatic chk_flag(input logic e, input logic g, input string m);
        chk_byte({7'h00, e}, {7'h00, g}, m);
    endtask
    task automatic hang();
        errors++;
        $display("MISMATCH %0t no answer", $time);
        results();
    endtask
    task automatic run(input op_e op, input logic [17:0] ad, input logic [7:0] dd);
        int n;
        req_valid <= 1'b1;
        req <= '{op: op, addr: ad, data: dd};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        if (req_ready !== 1'b1) hang();
        req_valid <= 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 50000) begin
            @(posedge clock);
            n++;
        end
        if (resp_valid !== 1'b1) hang();
        got = resp_data;
        fail = resp_fail;
    endtask
    task automatic prog(input logic [17:0] ad, input logic [7:0] dd);
        run(OP_PROGRAM, ad, dd);
        chk_flag((ref_rd(ad) & dd) != dd, fail, "program flag");
        ref_mem[ad] = ref_rd(ad) & dd;
    endtask
    // ====================
    // scenarios
    initial begin
        repeat (5) @(posedge clock);
        chk_flag(1'b1, chip_sel_n, "idle select");
        chk_flag(1'b0, dq_oe, "idle drive");
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            a = i == 0 ? '1 : {rnd, rnd[1:0]} | 18'h00010;
            rnd = lfsr(rnd);
            d = rnd[7:0];
            q.push_back(a);
            prog(a, d);
            run(OP_READ, a, ZERO_BYTE);
            chk_byte(ref_rd(a), got, "read back");
        end
        allow <= 1'b0;
        foreach (q[i]) begin
            run(OP_READ, q[i], ZERO_BYTE);
            chk_byte(ref_rd(q[i]), got, "read low supply");
        end
        base = strobes;
        fork
            prog(18'h00000, ZERO_BYTE);
            begin
                repeat (20) @(posedge clock);
                chk_byte(8'(base), 8'(strobes), "strobe without supply");
                allow <= 1'b1;
            end
        join
        for (int i = 0; i < 2; i++) begin
            run(OP_SIGNATURE, 18'(i), ZERO_BYTE);
            chk_byte(i == 0 ? MAKER : DEVICE, got, "signature");
        end
        pin_high <= 1'b1;
        run(OP_READ, q[1], ZERO_BYTE);
        chk_byte(ref_rd(q[1]), got, "read high supply");
        pin_high <= 1'b0;
        base = verifies;
        prog(18'h00000, ERASED_BYTE);
        chk_byte(8'(base + MAX_PROG_TRIES), 8'(verifies), "program tries");
        run(OP_ERASE, 18'h00000, ZERO_BYTE);
        chk_flag(1'b0, fail, "erase flag");
        ref_mem.delete();
        for (int i = 0; i <= LAST; i++) q.push_back(18'(i));
        foreach (q[i]) begin
            run(OP_READ, q[i], ZERO_BYTE);
            chk_byte(ref_rd(q[i]), got, "erased");
        end
        base = aborts;
        run(OP_ABORT, 18'h00000, ZERO_BYTE);
        chk_byte(8'(base + 1), 8'(aborts), "abort count");
        run(OP_READ, q[0], ZERO_BYTE);
        chk_byte(ERASED_BYTE, got, "read after abort");
        chk_byte(8'h00, 8'(faults), "device timing faults");
        results();
    end
endmodule // test_flash_host
